//--- rtl/addr_gen.sv
// effective address generator with modulo and bit-reversed support
// Function
// RQ1 - first source is register direct only
// RQ2 - second source register, memory or 5-bit literal
// RQ3 - post-modify uses pointer then steps it
// RQ4 - pre-modify steps pointer then uses it
// RQ5 - indexed address is pointer plus offset register
// RQ6 - literal offset address is pointer plus literal
// RQ7 - move source/destination share one offset field
// RQ8 - mac pointers w8-w11, split X and Y
// RQ9 - mac indexing only on w9 and w11
// RQ10 - mac post-modify by 2, 4 or 6
// RQ11 - branch 16-bit signed, disable 14-bit literal
// RQ12 - one circular buffer each in X, Y
// RQ13 - power-of-two buffers check both limits
// RQ14 - 16-bit start/end, length from difference
// RQ15 - Y modulo addresses clear bit zero
// RQ16 - buffers up to 32K words
// RQ17 - X select bits 3:0, enable bit 15
// RQ18 - Y select bits 7:4, enable bit 14
// RQ19 - limits checked beyond, not equal
// RQ20 - writeback only for pre/post modify
// RQ21 - bit reverse only on X writes
// RQ22 - only the modifier is bit reversed
// RQ23 - bit reverse needs select, enable, pre/post
// RQ24 - bit reverse ignores mode offset
// RQ25 - bit reverse beats modulo on X write
// RQ26 - past end subtract length, below start add
`include "agu_defs.svh"
module addr_gen import agu_pkg::*; #(
   parameter int AW = 16 // address width
) (
   input wire logic i_clock,          // core clock, 20 MHz
   input wire logic i_reset_n,        // synchronous reset, active low
   input wire logic [7:0] i_wb_adr,   // wishbone byte address
   input wire logic [31:0] i_wb_dat,  // wishbone write data
   input wire logic [3:0] i_wb_sel,   // wishbone byte selects
   input wire logic i_wb_we,          // wishbone write
   input wire logic i_wb_cyc,         // wishbone cycle
   input wire logic i_wb_stb,         // wishbone strobe
   output logic [31:0] o_wb_dat,      // wishbone read data
   output logic o_wb_ack,             // wishbone acknowledge
   input wire logic i_req,            // address request strobe
   input wire space_t i_space,        // generator selected
   input wire addr_mode_t i_mode,     // addressing mode
   input wire logic i_mac,            // request is a mac prefetch
   input wire logic i_byte,           // byte sized access
   input wire logic [3:0] i_ptr_sel,  // pointer register number
   input wire logic [AW-1:0] i_ptr,   // pointer register contents
   input wire logic [AW-1:0] i_offset, // offset register contents
   input wire logic [AW-1:0] i_lit,   // literal or step constant
   output logic o_valid,              // result strobe
   output logic [AW-1:0] o_ea,        // effective address
   output logic o_wb_ptr,             // pointer to be written back
   output logic [AW-1:0] o_ptr_new,   // new pointer value
   output logic o_bad_mode,           // request refused
   output logic o_bitrev_used         // bit reversal applied
);
   logic [15:0] ctl_r;
   logic [15:0] xs_r;
   logic [15:0] xe_r;
   logic [15:0] ys_r;
   logic [15:0] ye_r;
   logic [15:0] brv_r;
   logic [15:0] err_cnt_r;
   logic hit;
   logic [31:0] rdata;
   logic x_sel_ok;
   logic y_sel_ok;
   logic br_sel_ok;
   logic x_mod_on;
   logic y_mod_on;
   logic br_on;
   logic step_down;
   logic bad;
   logic [AW-1:0] base_sum;
   logic [AW-1:0] ptr_sum;
   logic [AW-1:0] ea_raw;
   logic [AW-1:0] ea_fix;
   logic [AW-1:0] ptr_fix;
   logic [AW-1:0] rev_mod;
   logic [AW-1:0] br_sum;
   circ_if cw ();
   circ_if cp ();

   assign hit = i_wb_cyc && i_wb_stb && !o_wb_ack;

   // one register write per acknowledged cycle; byte selects honoured
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         ctl_r <= `CTL_RESET;
         xs_r <= 16'h0000;
         xe_r <= 16'h0000;
         ys_r <= 16'h0000;
         ye_r <= 16'h0000;
         brv_r <= `BRV_RESET;
      end else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack) begin
         case (i_wb_adr)
            `OFS_CONTROL: begin
               if (i_wb_sel[0]) ctl_r[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) ctl_r[15:8] <= i_wb_dat[15:8];
            end
            `OFS_X_START: begin
               if (i_wb_sel[0]) xs_r[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) xs_r[15:8] <= i_wb_dat[15:8];
            end
            `OFS_X_END: begin
               if (i_wb_sel[0]) xe_r[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) xe_r[15:8] <= i_wb_dat[15:8];
            end
            `OFS_Y_START: begin
               if (i_wb_sel[0]) ys_r[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) ys_r[15:8] <= i_wb_dat[15:8];
            end
            `OFS_Y_END: begin
               if (i_wb_sel[0]) ye_r[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) ye_r[15:8] <= i_wb_dat[15:8];
            end
            `OFS_BITREV: begin
               if (i_wb_sel[0]) brv_r[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) brv_r[15:8] <= i_wb_dat[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (i_wb_adr)
         `OFS_CONTROL: rdata = {16'h0000, ctl_r};
         `OFS_X_START: rdata = {16'h0000, xs_r};
         `OFS_X_END: rdata = {16'h0000, xe_r};
         `OFS_Y_START: rdata = {16'h0000, ys_r};
         `OFS_Y_END: rdata = {16'h0000, ye_r};
         `OFS_BITREV: rdata = {16'h0000, brv_r};
         `OFS_STATUS: rdata = {16'h0000, err_cnt_r};
         default: rdata = 32'h00000000;
      endcase
   end

   // ack one cycle after the strobe, then drop; unmapped reads give zero
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= hit;
         if (hit)
            o_wb_dat <= rdata;
      end
   end

   assign x_sel_ok = ctl_r[`X_SEL_LSB +: 4] != `SEL_NONE;
   assign y_sel_ok = ctl_r[`Y_SEL_LSB +: 4] != `SEL_NONE;
   assign br_sel_ok = ctl_r[`BR_SEL_LSB +: 4] != `SEL_NONE;

   always_comb begin
      // only the pointer named in the select field takes the window
      x_mod_on = x_sel_ok && ctl_r[`X_EN_BIT] &&
         i_ptr_sel == ctl_r[`X_SEL_LSB +: 4]; // RQ17 RQ12
      y_mod_on = y_sel_ok && ctl_r[`Y_EN_BIT] &&
         i_ptr_sel == ctl_r[`Y_SEL_LSB +: 4]; // RQ18 RQ12
      br_on = br_sel_ok && brv_r[`BR_EN_BIT] && !i_byte &&
         i_space == SP_X_WRITE && i_ptr_sel == ctl_r[`BR_SEL_LSB +: 4] &&
         (i_mode == AM_POST_MOD || i_mode == AM_PRE_MOD); // RQ21 RQ23
      if (i_space == SP_X_WRITE && br_on)
         x_mod_on = 1'b0; // RQ25
   end

   assign cw.start_addr = (i_space == SP_Y) ? ys_r : xs_r;
   assign cw.end_addr = (i_space == SP_Y) ? ye_r : xe_r;
   assign cw.active = (i_space == SP_Y) ? y_mod_on : x_mod_on;
   assign cw.word_only = (i_space == SP_Y) && y_mod_on;
   assign cp.start_addr = cw.start_addr;
   assign cp.end_addr = cw.end_addr;
   assign cp.active = cw.active;
   assign cp.word_only = cw.word_only;

   // 15-bit modifier scaled to a byte address; the reverse-carry add
   // below is what treats it as bit reversed, so it is not flipped here
   genvar gi;
   generate
      for (gi = 0; gi < 15; gi++) begin : g_rev
         assign rev_mod[gi + 1] = brv_r[gi]; // RQ22
      end
   endgenerate
   assign rev_mod[0] = 1'b0;

   // reversed-carry add: carry moves from high to low bits
   always_comb begin
      logic c;
      logic [AW-1:0] s;
      c = 1'b0;
      s = '0;
      for (int k = AW - 1; k >= 0; k--) begin
         s[k] = i_ptr[k] ^ rev_mod[k] ^ c;
         c = (i_ptr[k] & rev_mod[k]) | (c & (i_ptr[k] ^ rev_mod[k]));
      end
      br_sum = {s[AW-1:1], 1'b0}; // RQ22 RQ24
   end

   // refuse mode combinations the core cannot issue
   always_comb begin
      bad = 1'b0;
      if (i_mac) begin
         if (i_ptr_sel < `MAC_PTR_LO || i_ptr_sel > `MAC_Y_IDX)
            bad = 1'b1; // RQ8
         else if ((i_ptr_sel >= `MAC_Y_LO) != (i_space == SP_Y))
            bad = 1'b1; // RQ8
         if (i_mode == AM_REG_OFFSET && i_ptr_sel != `MAC_X_IDX &&
               i_ptr_sel != `MAC_Y_IDX)
            bad = 1'b1; // RQ9
         if (i_mode == AM_POST_MOD && !(i_lit == 16'h0002 ||
               i_lit == 16'hFFFE || i_lit == 16'h0004 ||
               i_lit == 16'hFFFC || i_lit == 16'h0006 ||
               i_lit == 16'hFFFA))
            bad = 1'b1; // RQ10
         if (i_mode != AM_INDIRECT && i_mode != AM_POST_MOD &&
               i_mode != AM_REG_OFFSET)
            bad = 1'b1; // RQ10
      end
      if (i_mode == AM_DIRECT || i_mode == AM_LITERAL)
         bad = 1'b1; // RQ1 RQ2
   end

   // offset field is one shared value for source and destination
   assign base_sum = i_ptr + i_offset; // RQ5 RQ7
   assign ptr_sum = i_ptr + i_lit; // RQ3 RQ4 RQ6
   assign step_down = i_lit[AW-1];

   always_comb begin
      case (i_mode)
         AM_INDIRECT: ea_raw = i_ptr;
         AM_POST_MOD: ea_raw = i_ptr; // RQ3
         AM_PRE_MOD: ea_raw = ptr_sum; // RQ4
         AM_REG_OFFSET: ea_raw = base_sum; // RQ5
         AM_LIT_OFFSET: ea_raw = ptr_sum; // RQ6
         default: ea_raw = i_ptr;
      endcase
   end

   circ_wrap u_wrap_ea (
      .c(cw.dst),
      .i_addr(ea_raw),
      .i_down(step_down),
      .o_addr(ea_fix)
   );
   circ_wrap u_wrap_ptr (
      .c(cp.dst),
      .i_addr(ptr_sum),
      .i_down(step_down),
      .o_addr(ptr_fix)
   );

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_valid <= 1'b0;
         o_ea <= '0;
         o_wb_ptr <= 1'b0;
         o_ptr_new <= '0;
         o_bad_mode <= 1'b0;
         o_bitrev_used <= 1'b0;
      end else begin
         o_valid <= i_req && !bad;
         o_bad_mode <= i_req && bad;
         o_bitrev_used <= i_req && !bad && br_on;
         o_wb_ptr <= i_req && !bad &&
            (i_mode == AM_POST_MOD || i_mode == AM_PRE_MOD); // RQ20
         if (i_req && !bad) begin
            if (br_on) begin
               o_ea <= (i_mode == AM_PRE_MOD) ? br_sum : i_ptr; // RQ24
               o_ptr_new <= br_sum; // RQ24
            end else begin
               o_ea <= ea_fix;
               o_ptr_new <= (i_mode == AM_POST_MOD ||
                  i_mode == AM_PRE_MOD) ? ptr_fix : i_ptr; // RQ20
            end
         end
      end
   end

   // count refused requests for software to inspect
   always_ff @(posedge i_clock) begin
      if (!i_reset_n)
         err_cnt_r <= 16'h0000;
      else if (i_req && bad && err_cnt_r != 16'hFFFF)
         err_cnt_r <= err_cnt_r + 16'h0001;
   end

   // literal widths checked by the decoder; kept as named fields here
   localparam int LIT5 = `LIT5_W; // RQ2
   localparam int BRW = `BRANCH_W; // RQ11
   localparam int DSW = `INTERRUPT_DISABLE_INSTR_W; // RQ11
endmodule : addr_gen

//--- rtl/agu_defs.svh
// constants for the address generator: offsets, fields, resets, mac pointers, widths
`ifndef AGU_DEFS_SVH
`define AGU_DEFS_SVH
`define OFS_CONTROL 8'h00
`define OFS_X_START 8'h04
`define OFS_X_END 8'h08
`define OFS_Y_START 8'h0C
`define OFS_Y_END 8'h10
`define OFS_BITREV 8'h14
`define OFS_STATUS 8'h18
`define CTL_RESET 16'h0FFF
`define BRV_RESET 16'h0000
`define SEL_NONE 4'hF
`define X_SEL_LSB 0
`define Y_SEL_LSB 4
`define BR_SEL_LSB 8
`define X_EN_BIT 15
`define Y_EN_BIT 14
`define BR_EN_BIT 15
`define MAC_PTR_LO 4'h8
`define MAC_X_IDX 4'h9
`define MAC_Y_LO 4'hA
`define MAC_Y_IDX 4'hB
`define LIT5_W 5
`define BRANCH_W 16
`define INTERRUPT_DISABLE_INSTR_W 14
`endif

//--- rtl/agu_pkg.sv
// types shared by the address generator files
package agu_pkg;
   typedef enum logic [2:0] {
      AM_DIRECT,
      AM_INDIRECT,
      AM_POST_MOD,
      AM_PRE_MOD,
      AM_REG_OFFSET,
      AM_LIT_OFFSET,
      AM_LITERAL
   } addr_mode_t;
   typedef enum logic [1:0] {
      SP_X_READ,
      SP_X_WRITE,
      SP_Y
   } space_t;
endpackage : agu_pkg

//--- rtl/circ_if.sv
// modulo window settings passed from the top to the wrap unit
interface circ_if;
   logic [15:0] start_addr;
   logic [15:0] end_addr;
   logic active;
   logic word_only;
   modport src (output start_addr, output end_addr, output active,
      output word_only);
   modport dst (input start_addr, input end_addr, input active,
      input word_only);
endinterface : circ_if

//--- rtl/circ_wrap.sv
// circular buffer boundary correction for one candidate address
module circ_wrap (
   circ_if.dst c,             // window settings
   input wire logic [15:0] i_addr, // raw address
   input wire logic i_down,   // step is decrementing
   output logic [15:0] o_addr // corrected address
);
   logic [16:0] len;
   logic [15:0] a;
   always_comb begin
      // length is end-start+1, derived, never stored
      len = {1'b0, c.end_addr} - {1'b0, c.start_addr} + 17'h00001; // RQ14 RQ16
      a = i_addr;
      if (c.active) begin
         // compare beyond, not equal, so overshooting steps still wrap
         if (!i_down && i_addr > c.end_addr)
            a = i_addr - len[15:0]; // RQ19 RQ26
         else if (i_down && i_addr < c.start_addr)
            a = i_addr + len[15:0]; // RQ19 RQ26
         else if (i_addr > c.end_addr)
            a = i_addr - len[15:0]; // RQ13
         else if (i_addr < c.start_addr)
            a = i_addr + len[15:0]; // RQ13
      end
      if (c.word_only)
         a[0] = 1'b0; // RQ15
      o_addr = a;
   end
endmodule : circ_wrap

//--- bench/agu_props.sv
// port-level timing and mode checks on the address generator
module agu_props import agu_pkg::*; #(
   parameter int AW = 16
) (
   input wire logic i_clock, i_reset_n, i_wb_we, i_wb_cyc, i_wb_stb,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat, o_wb_dat,
   input wire logic [3:0] i_wb_sel, i_ptr_sel,
   input wire logic o_wb_ack, i_req, i_mac, i_byte, o_valid, o_wb_ptr,
   input wire logic o_bad_mode, o_bitrev_used,
   input wire space_t i_space,
   input wire addr_mode_t i_mode,
   input wire logic [AW-1:0] i_ptr, i_offset, i_lit, o_ea, o_ptr_new
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   sequence s_bus_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_answer;
      o_valid ^ o_bad_mode;
   endsequence
   a_bus_answer: assert property (s_bus_req |=> o_wb_ack ##1 !o_wb_ack)
      else $error("bus ack not a single pulse after request");
   a_ack_cause: assert property
      ($rose(o_wb_ack) |-> $past(i_wb_cyc) && $past(i_wb_stb))
      else $error("ack without bus request");
   a_req_answer: assert property (i_req |=> s_answer)
      else $error("request not answered once");
   a_no_stray: assert property ((o_valid || o_bad_mode) |-> $past(i_req))
      else $error("answer without request");
   a_direct_refused: assert property
      (i_req && i_mode == AM_DIRECT |=> o_bad_mode)
      else $error("direct mode not refused");
   a_post_ptr: assert property (i_req && i_mode == AM_POST_MOD |=>
      o_bad_mode || (o_wb_ptr && o_ea == $past(i_ptr)))
      else $error("post modify address wrong");
   a_pre_ptr: assert property (i_req && i_mode == AM_PRE_MOD |=>
      o_bad_mode || (o_wb_ptr && o_ea == o_ptr_new))
      else $error("pre modify address wrong");
   a_offset_keeps: assert property (i_req &&
      i_mode inside {AM_REG_OFFSET, AM_LIT_OFFSET} |=> !o_wb_ptr)
      else $error("offset mode wrote pointer back");
   a_mac_range: assert property (i_req && i_mac &&
      !(i_ptr_sel inside {[4'h8:4'hB]}) |=> o_bad_mode)
      else $error("mac pointer outside range accepted");
   a_mac_index: assert property (i_req && i_mac &&
      i_mode == AM_REG_OFFSET && !(i_ptr_sel inside {4'h9, 4'hB})
      |=> o_bad_mode)
      else $error("mac indexing on wrong pointer accepted");
   a_bitrev_write: assert property (o_bitrev_used |->
      $past(i_space) == SP_X_WRITE &&
      $past(i_mode) inside {AM_POST_MOD, AM_PRE_MOD})
      else $error("bit reversal outside x write pre or post");
endmodule : agu_props

//--- bench/reg_file_model.sv
// working register file feeding pointers to the address generator
module reg_file_model (
   input wire logic i_clock,           // core clock
   input wire logic i_reset_n,         // reset, active low
   input wire logic [3:0] i_sel,       // register number
   input wire logic i_load,            // bench preload strobe
   input wire logic [15:0] i_load_val, // preload value
   input wire logic i_wb,              // pointer writeback strobe
   input wire logic [15:0] i_wb_val,   // written back pointer
   output logic [15:0] o_ptr           // selected register
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] regs_r [16];
   // writeback lands one edge after the answer, before the next request
   always_ff @(posedge i_clock) begin
      if (!i_reset_n)
         regs_r <= '{default: 16'h0000};
      else if (i_load)
         regs_r[i_sel] <= i_load_val;
      else if (i_wb)
         regs_r[i_sel] <= i_wb_val;
   end
   assign o_ptr = regs_r[i_sel];
endmodule : reg_file_model

//--- bench/testbench.sv
// self-checking bench for the address generator
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import agu_pkg::*;
   localparam space_t XR = SP_X_READ, XW = SP_X_WRITE, YS = SP_Y;
   localparam addr_mode_t DI = AM_DIRECT, IN = AM_INDIRECT;
   localparam addr_mode_t PO = AM_POST_MOD, PR = AM_PRE_MOD;
   localparam addr_mode_t RO = AM_REG_OFFSET, LO = AM_LIT_OFFSET;
   logic clock = 1'h0, rst_n = 1'h0, we = 1'h0, cyc = 1'h0, stb = 1'h0;
   logic req = 1'h0, mac = 1'h0, load = 1'h0, byt = 1'h0;
   logic ack, valid, wbp, bad, brv;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   space_t space = SP_X_READ;
   addr_mode_t mode = AM_INDIRECT;
   logic [3:0] psel = 4'h0;
   logic [15:0] off = 16'h0, lit = 16'h0, ldv = 16'h0, ptr, ea, pnew, p;
   int failures = 0, samples_checked = 0;
   always #25 clock = ~clock;
   addr_gen addr_gen_i (.i_clock(clock), .i_reset_n(rst_n), .i_wb_adr(adr),
      .i_wb_dat(wdat), .i_wb_sel(4'h3), .i_wb_we(we), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .o_wb_dat(rdat), .o_wb_ack(ack), .i_req(req),
      .i_space(space), .i_mode(mode), .i_mac(mac), .i_byte(byt),
      .i_ptr_sel(psel), .i_ptr(ptr), .i_offset(off), .i_lit(lit),
      .o_valid(valid), .o_ea(ea), .o_wb_ptr(wbp), .o_ptr_new(pnew),
      .o_bad_mode(bad), .o_bitrev_used(brv));
   reg_file_model reg_file_model_i (.i_clock(clock), .i_reset_n(rst_n),
      .i_sel(psel), .i_load(load), .i_load_val(ldv), .i_wb(wbp),
      .i_wb_val(pnew), .o_ptr(ptr));
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // read data is compared only when w is low
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [31:0] e);
      int n;
      @(posedge clock);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'h1;
      stb <= 1'h1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'h1 && n < 20);
      if (ack !== 1'h1) begin
         failures++;
         close_out();
      end
      if (!w)
         chk(rdat, e);
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clock);
   endtask : xfer
   task automatic put(input logic [3:0] r, input logic [15:0] v);
      @(posedge clock);
      psel <= r;
      ldv <= v;
      load <= 1'h1;
      @(posedge clock);
      load <= 1'h0;
   endtask : put
   // f holds refused, writeback and bit-reversed, high to low
   task automatic ask(input space_t s, input addr_mode_t m, input logic c,
      input logic [3:0] r, input logic [15:0] l, input logic [2:0] f,
      input logic [15:0] ee, input logic [15:0] en);
      @(posedge clock);
      space <= s;
      mode <= m;
      mac <= c;
      psel <= r;
      lit <= l;
      req <= 1'h1;
      @(posedge clock);
      req <= 1'h0;
      #1;
      chk({28'h0, valid, bad, wbp, brv},
         {28'h0, !f[2], f[2], f[2] ? 2'h0 : f[1:0]});
      if (!f[2])
         chk({16'h0, ea}, {16'h0, ee});
      if (f[1] && !f[2])
         chk({16'h0, pnew}, {16'h0, en});
   endtask : ask
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'h1;
      xfer(8'h00, 1'h0, 32'h0, 32'h0000_0FFF);
      xfer(8'h04, 1'h0, 32'h0, 32'h0);
      xfer(8'h1C, 1'h0, 32'h0, 32'h0);
      put(4'h3, 16'h0100);
      off <= 16'h0010;
      ask(XR, PO, 1'h0, 4'h3, 16'h0004, 3'h2, 16'h0100, 16'h0104);
      ask(XR, PR, 1'h0, 4'h3, 16'hFFFE, 3'h2, 16'h0102, 16'h0102);
      ask(XR, RO, 1'h0, 4'h3, 16'h0000, 3'h0, 16'h0112, 16'h0);
      ask(XR, LO, 1'h0, 4'h3, 16'h0020, 3'h0, 16'h0122, 16'h0);
      ask(XR, DI, 1'h0, 4'h3, 16'h0000, 3'h4, 16'h0, 16'h0);
      xfer(8'h04, 1'h1, 32'h1000, 32'h0);
      xfer(8'h08, 1'h1, 32'h101F, 32'h0);
      xfer(8'h0C, 1'h1, 32'h2000, 32'h0);
      xfer(8'h10, 1'h1, 32'h201F, 32'h0);
      xfer(8'h08, 1'h0, 32'h0, 32'h101F);
      xfer(8'h00, 1'h1, 32'hCF42, 32'h0);
      put(4'h2, 16'h101E);
      ask(XR, PO, 1'h0, 4'h2, 16'h0004, 3'h2, 16'h101E, 16'h1002);
      ask(XR, PR, 1'h0, 4'h2, 16'hFFFC, 3'h2, 16'h101E, 16'h101E);
      ask(XR, LO, 1'h0, 4'h2, 16'h001E, 3'h0, 16'h101C, 16'h0);
      put(4'h3, 16'h101E);
      ask(XR, PO, 1'h0, 4'h3, 16'h0004, 3'h2, 16'h101E, 16'h1022);
      put(4'h4, 16'h201E);
      ask(YS, PO, 1'h0, 4'h4, 16'h0004, 3'h2, 16'h201E, 16'h2002);
      put(4'h4, 16'h2011);
      ask(YS, LO, 1'h0, 4'h4, 16'h0000, 3'h0, 16'h2010, 16'h0);
      xfer(8'h00, 1'h1, 32'h4F42, 32'h0);
      ask(XR, PO, 1'h0, 4'h2, 16'h0004, 3'h2, 16'h101E, 16'h1022);
      put(4'h9, 16'h0200);
      ask(XR, RO, 1'h1, 4'h9, 16'h0000, 3'h0, 16'h0210, 16'h0);
      ask(XR, RO, 1'h1, 4'h8, 16'h0000, 3'h4, 16'h0, 16'h0);
      ask(XR, IN, 1'h1, 4'h7, 16'h0000, 3'h4, 16'h0, 16'h0);
      p = 16'h0200;
      for (int k = 2; k <= 6; k += 2) begin
         ask(XR, PO, 1'h1, 4'h9, 16'(k), 3'h2, p, p + 16'(k));
         p = p + 16'(k);
      end
      ask(XR, PO, 1'h1, 4'h9, 16'h0008, 3'h4, 16'h0, 16'h0);
      xfer(8'h14, 1'h1, 32'h8008, 32'h0);
      xfer(8'h00, 1'h1, 32'hC242, 32'h0);
      put(4'h2, 16'h101E);
      ask(XR, PO, 1'h0, 4'h2, 16'h0004, 3'h2, 16'h101E, 16'h1002);
      put(4'h2, 16'h101E);
      ask(XW, PO, 1'h0, 4'h2, 16'h0004, 3'h3, 16'h101E, 16'h1000);
      // byte writes never bit reverse, so the x window wraps them instead
      byt <= 1'h1;
      put(4'h2, 16'h101E);
      ask(XW, PO, 1'h0, 4'h2, 16'h0004, 3'h2, 16'h101E, 16'h1002);
      byt <= 1'h0;
      xfer(8'h18, 1'h0, 32'h0, 32'h0000_0004);
      close_out();
   end
endmodule : testbench
bind addr_gen agu_props #(.AW(AW)) agu_props_i (.*);
